// ---- hw/wsr_status_bank.sv ----
// Purpose: Read-only status words and time-of-day clock of the weigher.
// Assumes: Status inputs are synchronous to clock_in and already settled.
// Notes:   Read data stand one cycle after the read strobe, zero otherwise.

`timescale 1ns/1ns
`default_nettype none

// Contract
// R1: Outputs 31-38 in bits 0-7, 41-48 in bits 8-15, 1 = active.
// R2: Outputs 51-58 in bits 0-7, 61-68 in bits 8-15, 1 = active.
// R3: Level word low: bit n set while weight is above level n+1.
// R4: Level word high: bit n set while weight is above level n+17.
// R5: Setpoints 1-8: activated in bit 2k, cycle done in bit 2k+1.
// R6: Setpoints 9-16 use the same paired layout in a second word.
// R7: A float-format read returns the word converted, not raw bits.
// R8: Clock registers give the current time and date.
// R9: Status and clock registers ignore writes.
module wsr_status_bank #(
   parameter int unsigned TICK_CYCLES = wsr_pkg::TICK_CYCLES
) (
   input  wire logic                 clock_in,
   input  wire logic                 rst_n_in,
   input  wire logic [4:0]           addr_in,
   input  wire logic [31:0]          wr_data_in,
   input  wire logic                 wr_en_in,
   input  wire logic                 rd_en_in,
   output logic      [31:0]          rd_data_out,
   output logic                      irq_out,
   input  wire wsr_pkg::wsr_status_t status_in,
   input  wire logic                 time_load_in,
   input  wire wsr_pkg::wsr_rtc_t    time_set_in
);

   // ==========================================================
   // Declarations
   // ==========================================================
   localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);

   logic [15:0] out_b_ff;
   logic [15:0] out_c_ff;
   logic [15:0] level_lo_ff;
   logic [15:0] level_hi_ff;
   logic [15:0] sp_lo_ff;
   logic [15:0] sp_hi_ff;

   logic [15:0] nxt_out_b;
   logic [15:0] nxt_out_c;
   logic [15:0] nxt_level_lo;
   logic [15:0] nxt_level_hi;
   logic [15:0] nxt_sp_lo;
   logic [15:0] nxt_sp_hi;

   logic [23:0] tick_cnt_ff;
   logic        tick;
   logic [7:0]  sec_ff;
   logic [7:0]  min_ff;
   logic [7:0]  hour_ff;
   logic [7:0]  day_ff;
   logic [7:0]  month_ff;
   logic [15:0] year_ff;
   logic        sec_wrap;
   logic        min_wrap;
   logic        hour_wrap;
   logic        day_wrap;
   logic        month_wrap;
   logic [7:0]  month_len;

   logic [6:0]  irq_stat_ff;
   logic [6:0]  irq_mask_ff;
   logic [6:0]  nxt_irq_stat;
   logic [6:0]  nxt_irq_mask;
   logic [6:0]  irq_event;
   logic [6:0]  irq_clear;
   logic        irq_ff;

   // Read path and float view
   logic [31:0] rd_data_ff;
   logic [31:0] read_word;
   logic [15:0] float_src;
   logic [31:0] float_word;
   logic [31:0] time_word;
   logic [31:0] date_word;

   // ==========================================================
   // Status word assembly
   // ==========================================================
   // Digital output groups, first digit of each pair in the low byte
   assign nxt_out_b = {status_in.out_4x, status_in.out_3x}; // see R1
   assign nxt_out_c = {status_in.out_6x, status_in.out_5x}; // see R2

   // Level flags split over two words, level 1 in bit 0
   // Level 17 lands in bit 0 of the high word
   assign nxt_level_lo = status_in.level_above[15:0];  // see R3
   assign nxt_level_hi = status_in.level_above[31:16]; // see R4

   // Interleave activated and cycle-done flags per setpoint
   for (genvar k = 0; k < 8; k++) begin : g_sp
      assign nxt_sp_lo[2*k]   = status_in.sp_active[k];   // see R5
      assign nxt_sp_lo[2*k+1] = status_in.sp_done[k];     // see R5
      assign nxt_sp_hi[2*k]   = status_in.sp_active[k+8]; // see R6
      assign nxt_sp_hi[2*k+1] = status_in.sp_done[k+8];   // see R6
   end

   // Snapshot so a read sees one coherent word, not a moving input
   // Costs one cycle of latency on every word
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         out_b_ff    <= 16'h0000;
         out_c_ff    <= 16'h0000;
         level_lo_ff <= 16'h0000;
         level_hi_ff <= 16'h0000;
         sp_lo_ff    <= 16'h0000;
         sp_hi_ff    <= 16'h0000;
      end else begin
         out_b_ff    <= nxt_out_b;    // see R1
         out_c_ff    <= nxt_out_c;    // see R2
         level_lo_ff <= nxt_level_lo; // see R3
         level_hi_ff <= nxt_level_hi; // see R4
         sp_lo_ff    <= nxt_sp_lo;    // see R5
         sp_hi_ff    <= nxt_sp_hi;    // see R6
      end
   end

   // ==========================================================
   // Time-of-day clock
   // ==========================================================
   // One-second prescaler; a load restarts the second
   // so the first second after a load is a full one
   assign tick = (tick_cnt_ff == TICK_LAST);

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         tick_cnt_ff <= 24'h000000;
      end else if (time_load_in || tick) begin
         tick_cnt_ff <= 24'h000000;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 24'h000001;
      end
   end

   // Month length, leap years every fourth year only
   // Limitation: century years count as leap years
   always_comb begin
      case (month_ff)
         8'h02: begin
            month_len = (year_ff[1:0] == 2'h0) ? 8'h1D : 8'h1C;
         end
         8'h04, 8'h06, 8'h09, 8'h0B: begin
            month_len = 8'h1E;
         end
         default: begin
            month_len = 8'h1F;
         end
      endcase
   end

   // Carry chain from seconds up to years
   // Each carry needs every lower carry in the same cycle
   assign sec_wrap   = tick && (sec_ff == wsr_pkg::SEC_LAST);
   assign min_wrap   = sec_wrap && (min_ff == wsr_pkg::SEC_LAST);
   assign hour_wrap  = min_wrap && (hour_ff == wsr_pkg::HOUR_LAST);
   assign day_wrap   = hour_wrap && (day_ff >= month_len);
   assign month_wrap = day_wrap && (month_ff >= wsr_pkg::MONTH_LAST);

   // Seconds, minutes and hours
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         sec_ff  <= wsr_pkg::RST_SEC;
         min_ff  <= wsr_pkg::RST_MIN;
         hour_ff <= wsr_pkg::RST_HOUR;
      end else if (time_load_in) begin
         sec_ff  <= time_set_in.sec;
         min_ff  <= time_set_in.min;
         hour_ff <= time_set_in.hour;
      end else begin
         if (sec_wrap) begin
            sec_ff <= 8'h00;
         end else if (tick) begin
            sec_ff <= sec_ff + 8'h01; // see R8
         end
         if (min_wrap) begin
            min_ff <= 8'h00;
         end else if (sec_wrap) begin
            min_ff <= min_ff + 8'h01;
         end
         if (hour_wrap) begin
            hour_ff <= 8'h00;
         end else if (min_wrap) begin
            hour_ff <= hour_ff + 8'h01;
         end
      end
   end

   // Day, month and year
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         day_ff   <= wsr_pkg::RST_DAY;
         month_ff <= wsr_pkg::RST_MONTH;
         year_ff  <= wsr_pkg::RST_YEAR;
      end else if (time_load_in) begin
         day_ff   <= time_set_in.day;
         month_ff <= time_set_in.month;
         year_ff  <= time_set_in.year;
      end else begin
         if (day_wrap) begin
            day_ff <= 8'h01;
         end else if (hour_wrap) begin
            day_ff <= day_ff + 8'h01; // see R8
         end
         if (month_wrap) begin
            month_ff <= 8'h01;
         end else if (day_wrap) begin
            month_ff <= month_ff + 8'h01;
         end
         if (month_wrap) begin
            year_ff <= year_ff + 16'h0001;
         end
      end
   end

   // Packed views as software reads them
   always_comb begin
      time_word = 32'h00000000;
      date_word = 32'h00000000;
      time_word[wsr_pkg::SEC_LSB +: 8]    = sec_ff;    // see R8
      time_word[wsr_pkg::MIN_LSB +: 8]    = min_ff;
      time_word[wsr_pkg::HOUR_LSB +: 8]   = hour_ff;
      date_word[wsr_pkg::DAY_LSB +: 8]    = day_ff;    // see R8
      date_word[wsr_pkg::MONTH_LSB +: 8]  = month_ff;
      date_word[wsr_pkg::YEAR_LSB +: 16]  = year_ff;
   end

   // ==========================================================
   // Interrupt status and mask
   // ==========================================================
   // A status word that changes raises its own event bit
   // The tick bit fires each second; mask it to poll quietly
   assign irq_event[0] = (nxt_out_b != out_b_ff);
   assign irq_event[1] = (nxt_out_c != out_c_ff);
   assign irq_event[2] = (nxt_level_lo != level_lo_ff);
   assign irq_event[3] = (nxt_level_hi != level_hi_ff);
   assign irq_event[4] = (nxt_sp_lo != sp_lo_ff);
   assign irq_event[5] = (nxt_sp_hi != sp_hi_ff);
   assign irq_event[wsr_pkg::IRQ_TICK] = tick;

   // Write one to clear
   assign irq_clear = (wr_en_in && addr_in == wsr_pkg::OFS_IRQ_STAT)
                    ? wr_data_in[wsr_pkg::IRQ_W-1:0] : 7'h00;

   // Set beats clear so an event in the clearing cycle survives
   assign nxt_irq_stat = (irq_stat_ff & ~irq_clear) | irq_event;
   assign nxt_irq_mask = (wr_en_in && addr_in == wsr_pkg::OFS_IRQ_MASK)
                       ? wr_data_in[wsr_pkg::IRQ_W-1:0] : irq_mask_ff;

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         irq_stat_ff <= wsr_pkg::RST_IRQ;
         irq_mask_ff <= wsr_pkg::RST_IRQ;
         irq_ff      <= 1'b0;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
         irq_mask_ff <= nxt_irq_mask;
         irq_ff      <= |(nxt_irq_stat & nxt_irq_mask);
      end
   end

   // ==========================================================
   // Read path
   // ==========================================================
   // Source word for the float alias window
   // Clock and interrupt words have no float view
   always_comb begin
      case (addr_in[2:0])
         3'h0:    float_src = out_b_ff;
         3'h1:    float_src = out_c_ff;
         3'h2:    float_src = level_lo_ff;
         3'h3:    float_src = level_hi_ff;
         3'h4:    float_src = sp_lo_ff;
         3'h5:    float_src = sp_hi_ff;
         default: float_src = 16'h0000;
      endcase
   end

   // Integer bit pattern to single precision
   wsr_u16_to_f32 wsr_u16_to_f32_inst (
      .value_in  (float_src),
      .float_out (float_word)
   );

   // Address decode; unmapped words read as zero
   // Bit 4 picks the float window; status words read zero in their upper halves
   always_comb begin
      read_word = 32'h00000000;
      if (addr_in[wsr_pkg::FLOAT_BIT]) begin
         if (addr_in[3:0] < {1'b0, wsr_pkg::STATUS_WORDS}) begin
            read_word = float_word; // see R7
         end
      end else begin
         case (addr_in)
            wsr_pkg::OFS_OUT_B:    read_word = {16'h0000, out_b_ff};
            wsr_pkg::OFS_OUT_C:    read_word = {16'h0000, out_c_ff};
            wsr_pkg::OFS_LEVEL_LO: read_word = {16'h0000, level_lo_ff};
            wsr_pkg::OFS_LEVEL_HI: read_word = {16'h0000, level_hi_ff};
            wsr_pkg::OFS_SP_LO:    read_word = {16'h0000, sp_lo_ff};
            wsr_pkg::OFS_SP_HI:    read_word = {16'h0000, sp_hi_ff};
            wsr_pkg::OFS_TIME:     read_word = time_word;
            wsr_pkg::OFS_DATE:     read_word = date_word;
            wsr_pkg::OFS_IRQ_STAT: read_word = {25'h0000000, irq_stat_ff};
            wsr_pkg::OFS_IRQ_MASK: read_word = {25'h0000000, irq_mask_ff};
            default:               read_word = 32'h00000000;
         endcase
      end
   end

   // Data stand only in the cycle after the strobe, to keep the bus quiet
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         rd_data_ff <= 32'h00000000;
      end else if (rd_en_in) begin
         rd_data_ff <= read_word;
      end else begin
         rd_data_ff <= 32'h00000000;
      end
   end

   // ==========================================================
   // Write path
   // ==========================================================
   // Only the interrupt pair takes writes; everything else has no
   // write port at all, so a stray write cannot disturb a reading
   // see R9
   // Time is set only through time_load_in, never by software

   // ==========================================================
   // Outputs
   // ==========================================================
   // Both come straight from flops, no logic after them
   assign rd_data_out = rd_data_ff;
   assign irq_out     = irq_ff;

endmodule : wsr_status_bank

`default_nettype wire

// ---- include/wsr_pkg.sv ----
// Purpose: Shared constants and carriers of the weigher status bank.
// Assumes: 10 MHz clock, word-indexed register port, 32-bit read data.
// Notes:   Status words are 16 bits wide and sit in the low half.

`default_nettype none

package wsr_pkg;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned SECOND_NS     = 1000000000;
   localparam int unsigned TICK_CYCLES   = SECOND_NS / CLK_PERIOD_NS;
   localparam int unsigned TICK_W        = 24;

   // ==========================================================
   // Register port geometry
   // ==========================================================
   localparam int unsigned AW = 5;
   localparam int unsigned DW = 32;
   localparam int unsigned HW = 16;

   // ==========================================================
   // Register offsets (word index)
   // ==========================================================
   localparam logic [4:0] OFS_OUT_B     = 5'h00;
   localparam logic [4:0] OFS_OUT_C     = 5'h01;
   localparam logic [4:0] OFS_LEVEL_LO  = 5'h02;
   localparam logic [4:0] OFS_LEVEL_HI  = 5'h03;
   localparam logic [4:0] OFS_SP_LO     = 5'h04;
   localparam logic [4:0] OFS_SP_HI     = 5'h05;
   localparam logic [4:0] OFS_TIME      = 5'h06;
   localparam logic [4:0] OFS_DATE      = 5'h07;
   localparam logic [4:0] OFS_IRQ_STAT  = 5'h08;
   localparam logic [4:0] OFS_IRQ_MASK  = 5'h09;
   localparam int unsigned FLOAT_BIT    = 4;
   localparam logic [2:0] STATUS_WORDS  = 3'h6;

   // ==========================================================
   // Field positions and reset values
   // ==========================================================
   localparam int unsigned SEC_LSB   = 0;
   localparam int unsigned MIN_LSB   = 8;
   localparam int unsigned HOUR_LSB  = 16;
   localparam int unsigned DAY_LSB   = 0;
   localparam int unsigned MONTH_LSB = 8;
   localparam int unsigned YEAR_LSB  = 16;
   localparam logic [7:0]  RST_SEC   = 8'h00;
   localparam logic [7:0]  RST_MIN   = 8'h00;
   localparam logic [7:0]  RST_HOUR  = 8'h00;
   localparam logic [7:0]  RST_DAY   = 8'h01;
   localparam logic [7:0]  RST_MONTH = 8'h01;
   localparam logic [15:0] RST_YEAR  = 16'h07D0;
   localparam logic [7:0]  SEC_LAST  = 8'h3B;
   localparam logic [7:0]  HOUR_LAST = 8'h17;
   localparam logic [7:0]  MONTH_LAST = 8'h0C;

   // Interrupt bits: one per status word plus the seconds tick
   localparam int unsigned IRQ_W    = 7;
   localparam int unsigned IRQ_TICK = 6;
   localparam logic [6:0]  RST_IRQ  = 7'h00;

   // Single precision layout
   localparam logic [7:0]  FLOAT_BIAS = 8'h7F;

   // ==========================================================
   // Carriers
   // ==========================================================
   typedef struct packed {
      logic [7:0]  out_6x;
      logic [7:0]  out_5x;
      logic [7:0]  out_4x;
      logic [7:0]  out_3x;
      logic [31:0] level_above;
      logic [15:0] sp_done;
      logic [15:0] sp_active;
   } wsr_status_t;

   typedef struct packed {
      logic [15:0] year;
      logic [7:0]  month;
      logic [7:0]  day;
      logic [7:0]  hour;
      logic [7:0]  min;
      logic [7:0]  sec;
   } wsr_rtc_t;

endpackage : wsr_pkg

`default_nettype wire

// ---- hw/wsr_u16_to_f32.sv ----
// Purpose: Turns an unsigned 16-bit word into a single-precision float.
// Assumes: Combinational; exact, since 16 bits fit the 24-bit mantissa.
// Notes:   Zero maps to +0.0.

`timescale 1ns/1ns
`default_nettype none

module wsr_u16_to_f32 (
   input  wire logic [15:0] value_in,
   output logic      [31:0] float_out
);

   // ==========================================================
   // Leading one search and normalisation
   // ==========================================================
   logic [3:0]  msb_pos;
   logic [38:0] wide;
   logic [7:0]  expo;

   // Highest set bit wins, so scan upward
   always_comb begin
      msb_pos = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (value_in[i]) begin
            msb_pos = i[3:0];
         end
      end
   end

   // Hidden bit lands on position 23 after the shift
   assign wide = {value_in, 23'h000000} >> msb_pos;
   assign expo = wsr_pkg::FLOAT_BIAS + {4'h0, msb_pos};

   always_comb begin
      if (value_in == 16'h0000) begin
         float_out = 32'h00000000;
      end else begin
         float_out = {1'b0, expo, wide[22:0]};
      end
   end

endmodule : wsr_u16_to_f32

`default_nettype wire

// ---- verification/wsr_status_bank_props.sv ----
// Purpose: Port-level checks of the weigher status bank.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound into every wsr_status_bank instance.
`timescale 1ns/1ns
`default_nettype none

module wsr_status_bank_props #(
   parameter int unsigned TICK_CYCLES = 5
) (
   input wire logic                 clock_in,
   input wire logic                 rst_n_in,
   input wire logic [4:0]           addr_in,
   input wire logic [31:0]          wr_data_in,
   input wire logic                 wr_en_in,
   input wire logic                 rd_en_in,
   input wire logic [31:0]          rd_data_out,
   input wire logic                 irq_out,
   input wire wsr_pkg::wsr_status_t status_in,
   input wire logic                 time_load_in,
   input wire wsr_pkg::wsr_rtc_t    time_set_in
);
   // ==========================================================
   // Helpers
   // ==========================================================
   // Setpoint words rebuilt from the flags, activated even, done odd
   logic [15:0] sp_lo;
   logic [15:0] sp_hi;
   always_comb begin
      for (int k = 0; k < 8; k++) begin
         sp_lo[2*k]   = status_in.sp_active[k];
         sp_lo[2*k+1] = status_in.sp_done[k];
         sp_hi[2*k]   = status_in.sp_active[k+8];
         sp_hi[2*k+1] = status_in.sp_done[k+8];
      end
   end

   default clocking dclk @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_in);

   // Inputs must hold a cycle, since the words are a registered snapshot
   property word_p(logic [4:0] ofs, logic [15:0] val);
      rd_en_in && addr_in == ofs && $past(rst_n_in) && $stable(status_in)
      |=> rd_data_out == {16'h0000, $past(val)};
   endproperty

   // ==========================================================
   // Assertions
   // ==========================================================
   AST_OUT_B: assert property (
      word_p(wsr_pkg::OFS_OUT_B, {status_in.out_4x, status_in.out_3x}))
      else $error("output word b wrong");
   AST_OUT_C: assert property (
      word_p(wsr_pkg::OFS_OUT_C, {status_in.out_6x, status_in.out_5x}))
      else $error("output word c wrong");
   AST_LEVEL_LO: assert property (
      word_p(wsr_pkg::OFS_LEVEL_LO, status_in.level_above[15:0]))
      else $error("low level word wrong");
   AST_LEVEL_HI: assert property (
      word_p(wsr_pkg::OFS_LEVEL_HI, status_in.level_above[31:16]))
      else $error("high level word wrong");
   AST_SP_LO: assert property (
      word_p(wsr_pkg::OFS_SP_LO, sp_lo))
      else $error("low setpoint word wrong");
   AST_SP_HI: assert property (
      word_p(wsr_pkg::OFS_SP_HI, sp_hi))
      else $error("high setpoint word wrong");
   AST_FLOAT_POS: assert property (
      rd_en_in && addr_in[4] |=> !rd_data_out[31])
      else $error("float alias negative");
   AST_TIME_TOP: assert property (
      rd_en_in && addr_in == wsr_pkg::OFS_TIME |=> rd_data_out[31:24] == 8'h00)
      else $error("time word top byte set");
   AST_RD_IDLE: assert property (
      !rd_en_in |=> rd_data_out == 32'h0000_0000)
      else $error("read data outside read cycle");
   AST_MASK_OFF: assert property (
      wr_en_in && addr_in == wsr_pkg::OFS_IRQ_MASK && wr_data_in == 32'h0000_0000
      |=> !irq_out [*2])
      else $error("irq high with mask cleared");
   AST_LOAD_TIME: assert property (
      (TICK_CYCLES > 2 && time_load_in) ##2 (rd_en_in && addr_in == wsr_pkg::OFS_TIME)
      |=> rd_data_out == {8'h00, $past(time_set_in.hour, 3),
                          $past(time_set_in.min, 3), $past(time_set_in.sec, 3)})
      else $error("loaded time not read back");

   // Main scenarios reached
   COV_READ: cover property (rd_en_in ##1 rd_data_out != 32'h0000_0000);
   COV_IRQ: cover property ($rose(irq_out));
   COV_LOAD: cover property (time_load_in);
endmodule : wsr_status_bank_props

bind wsr_status_bank wsr_status_bank_props #(
   .TICK_CYCLES(TICK_CYCLES)
) wsr_status_bank_props_inst (
   .clock_in    (clock_in),
   .rst_n_in    (rst_n_in),
   .addr_in     (addr_in),
   .wr_data_in  (wr_data_in),
   .wr_en_in    (wr_en_in),
   .rd_en_in    (rd_en_in),
   .rd_data_out (rd_data_out),
   .irq_out     (irq_out),
   .status_in   (status_in),
   .time_load_in(time_load_in),
   .time_set_in (time_set_in)
);
`default_nettype wire

// ---- verification/wsr_status_bank_bench.sv ----
// Purpose: Self-checking bench of the weigher status bank.
// Assumes: Short second of 5 clocks to keep the run brief.
// Notes:   Expected words are worked out by hand from the bit maps.
`timescale 1ns/1ns
`default_nettype none

module wsr_status_bank_bench;
   localparam int unsigned TICKS = 5;
   logic                 clock_in;
   logic                 rst_n_in;
   logic [4:0]           addr_in;
   logic [31:0]          wr_data_in;
   logic                 wr_en_in;
   logic                 rd_en_in;
   logic [31:0]          rd_data_out;
   logic                 irq_out;
   wsr_pkg::wsr_status_t st;
   logic                 time_load_in;
   wsr_pkg::wsr_rtc_t    ts;
   int                   n_errors;
   int                   cmp_count;
   logic [15:0]          exp_w [6];
   logic [31:0]          exp_f [6];

   wsr_status_bank #(.TICK_CYCLES(TICKS)) wsr_status_bank_inst (
      .clock_in    (clock_in),
      .rst_n_in    (rst_n_in),
      .addr_in     (addr_in),
      .wr_data_in  (wr_data_in),
      .wr_en_in    (wr_en_in),
      .rd_en_in    (rd_en_in),
      .rd_data_out (rd_data_out),
      .irq_out     (irq_out),
      .status_in   (st),
      .time_load_in(time_load_in),
      .time_set_in (ts)
   );

   // ==========================================================
   // Clock and watchdog
   // ==========================================================
   initial begin
      clock_in = 1'b0;
      forever #50 clock_in = ~clock_in;
   end

   // Whole run is about 150 cycles, so 3000 means a hang
   initial begin
      repeat (3000) @(posedge clock_in);
      n_errors++;
      final_report();
   end

   // ==========================================================
   // Tasks
   // ==========================================================
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // Write strobe for one cycle; results are settled on return
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clock_in);
      addr_in    <= a;
      wr_data_in <= d;
      wr_en_in   <= 1'b1;
      @(posedge clock_in);
      wr_en_in <= 1'b0;
      #1;
   endtask : wr

   // Data only stand in the cycle after the strobe, so sample there
   task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input string what,
                         input logic [31:0] m = 32'hFFFF_FFFF);
      @(posedge clock_in);
      addr_in  <= a;
      rd_en_in <= 1'b1;
      @(posedge clock_in);
      rd_en_in <= 1'b0;
      #1;
      chk(rd_data_out & m, exp, what);
   endtask : rd_chk

   task automatic test_end(input string name);
      $display("test %s done, %0d mismatches so far", name, n_errors);
   endtask : test_end

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report

   // ==========================================================
   // Tests
   // ==========================================================
   initial begin
      n_errors = 0;
      cmp_count = 0;
      rst_n_in = 1'b0;
      addr_in = 5'h00;
      wr_data_in = 32'h0000_0000;
      wr_en_in = 1'b0;
      rd_en_in = 1'b0;
      st = '0;
      ts = '0;
      time_load_in = 1'b0;
      exp_w = '{16'h3CA5, 16'hF00F, 16'h8001, 16'h1234, 16'h8001, 16'h4002};
      exp_f = '{32'h3F80_0000, 32'h4700_0000, 32'h4700_0100,
                32'h0000_0000, 32'h4700_0100, 32'h4680_0400};
      repeat (20) @(posedge clock_in);
      rst_n_in <= 1'b1;

      // Reset state of words, mask, date and interrupt line
      for (int a = 0; a < 6; a++) rd_chk(a[4:0], 32'h0, "reset word");
      rd_chk(wsr_pkg::OFS_DATE, {16'h07D0, 8'h01, 8'h01}, "reset date");
      rd_chk(wsr_pkg::OFS_IRQ_MASK, 32'h0, "reset mask");
      chk({31'h0, irq_out}, 32'h0, "reset irq");
      test_end("reset");

      // Distinct patterns per field expose swapped bytes and pairings
      @(posedge clock_in);
      st <= {8'hF0, 8'h0F, 8'h3C, 8'hA5, 32'h1234_8001, 16'h0180, 16'h8001};
      for (int a = 0; a < 6; a++) rd_chk(a[4:0], {16'h0, exp_w[a]}, "map");
      rd_chk(5'h0A, 32'h0, "unmapped low");
      rd_chk(5'h16, 32'h0, "unmapped high");
      test_end("map");

      // Writes to status and clock places leave them untouched
      for (int a = 0; a < 8; a++) wr(a[4:0], 32'hFFFF_FFFF);
      for (int a = 0; a < 6; a++) rd_chk(a[4:0], {16'h0, exp_w[a]}, "after write");
      rd_chk(wsr_pkg::OFS_DATE, {16'h07D0, 8'h01, 8'h01}, "date after write");
      test_end("read only");

      // Float view: powers of two and an odd mantissa
      @(posedge clock_in);
      st <= {8'h80, 8'h00, 8'h00, 8'h01, 32'h0000_8001, 16'h0180, 16'h8001};
      for (int a = 0; a < 6; a++) rd_chk(5'h10 + a[4:0], exp_f[a], "float");
      test_end("float");

      // Change event, masking, one-write clear and the seconds tick
      wr(wsr_pkg::OFS_IRQ_MASK, 32'h0000_003F);
      wr(wsr_pkg::OFS_IRQ_STAT, 32'h0000_007F);
      chk({31'h0, irq_out}, 32'h0, "irq after clear");
      @(posedge clock_in);
      st.level_above <= 32'h0000_8000;
      rd_chk(wsr_pkg::OFS_IRQ_STAT, 32'h04, "irq status", 32'h3F);
      chk({31'h0, irq_out}, 32'h1, "irq raised");
      wr(wsr_pkg::OFS_IRQ_MASK, 32'h0000_003B);
      chk({31'h0, irq_out}, 32'h0, "irq masked");
      wr(wsr_pkg::OFS_IRQ_MASK, 32'h0000_003F);
      chk({31'h0, irq_out}, 32'h1, "irq unmasked");
      wr(wsr_pkg::OFS_IRQ_STAT, 32'h0000_0004);
      chk({31'h0, irq_out}, 32'h0, "irq cleared");
      rd_chk(wsr_pkg::OFS_IRQ_STAT, 32'h00, "irq status cleared", 32'h3F);
      wr(wsr_pkg::OFS_IRQ_MASK, 32'h0000_0040);
      chk({31'h0, irq_out}, 32'h1, "tick irq");
      wr(wsr_pkg::OFS_IRQ_MASK, 32'h0000_0000);
      chk({31'h0, irq_out}, 32'h0, "irq off");
      test_end("interrupt");

      // Load 23:59:58 on 28 Feb of a leap year, two ticks roll over to 00:00:00 on 29 Feb
      @(posedge clock_in);
      ts <= {16'h07E4, 8'h02, 8'h1C, 8'h17, 8'h3B, 8'h3A};
      time_load_in <= 1'b1;
      @(posedge clock_in);
      time_load_in <= 1'b0;
      rd_chk(wsr_pkg::OFS_TIME, 32'h0017_3B3A, "loaded time");
      repeat (8) @(posedge clock_in);
      rd_chk(wsr_pkg::OFS_TIME, 32'h0000_0000, "rolled time");
      rd_chk(wsr_pkg::OFS_DATE, {16'h07E4, 8'h02, 8'h1D}, "leap date");
      // Last second of a year carries through day, month and year
      @(posedge clock_in);
      ts <= {16'h07E7, 8'h0C, 8'h1F, 8'h17, 8'h3B, 8'h3B};
      time_load_in <= 1'b1;
      @(posedge clock_in);
      time_load_in <= 1'b0;
      repeat (8) @(posedge clock_in);
      rd_chk(wsr_pkg::OFS_DATE, {16'h07E8, 8'h01, 8'h01}, "new year");
      test_end("clock");
      final_report();
   end
endmodule : wsr_status_bank_bench
`default_nettype wire
